// ===== hw/pwmseq_pkg.sv
// types of the pwm output sequencer
package pwmseq_pkg;
    typedef enum logic [1:0] {PWMSEQ_LIM100, PWMSEQ_LIM75, PWMSEQ_LIM50, PWMSEQ_LIMBAD} pwmseq_limit_t;
    typedef struct packed {
        logic primaryDriveA;
        logic primaryDriveB;
        logic rectifierDriveA;
        logic rectifierDriveB;
    } pwmseq_drive_t;
endpackage

// ===== hw/pwmseq_regs.svh
// register offsets, reset values and timing counts of the pwm output sequencer
`ifndef PWMSEQ_REGS_SVH
`define PWMSEQ_REGS_SVH
`define PWMSEQ_CLK_MHZ        100
`define PWMSEQ_ADDR_CTRL      8'h00
`define PWMSEQ_ADDR_PS_DEAD   8'h04
`define PWMSEQ_ADDR_SP_DEAD   8'h08
`define PWMSEQ_ADDR_BLANK     8'h0C
`define PWMSEQ_ADDR_STATUS    8'h10
`define PWMSEQ_CTRL_RST       8'h00
// control fields
`define PWMSEQ_CTRL_FIXED     0
`define PWMSEQ_CTRL_PS_SET    1
`define PWMSEQ_CTRL_SP_SET    2
`define PWMSEQ_CTRL_EXTSYNC   3
// times in ns and derived cycle counts
`define PWMSEQ_MIN_DEAD_NS    8
`define PWMSEQ_FIX_DEAD_NS    50
`define PWMSEQ_FIX_BLANK_NS   50
`define PWMSEQ_MIN_DEAD_CYC   (((`PWMSEQ_MIN_DEAD_NS * `PWMSEQ_CLK_MHZ) + 999) / 1000)
`define PWMSEQ_FIX_DEAD_CYC   (((`PWMSEQ_FIX_DEAD_NS * `PWMSEQ_CLK_MHZ) + 999) / 1000)
`define PWMSEQ_FIX_BLANK_CYC  (((`PWMSEQ_FIX_BLANK_NS * `PWMSEQ_CLK_MHZ) + 999) / 1000)
`define PWMSEQ_LOGIC_DLY_CYC  2
`define PWMSEQ_DEAD_RST       8'h05
`define PWMSEQ_BLANK_RST      8'h05
`endif

// ===== hw/pwmseq_top.sv
// output sequencing of a current-mode pwm controller with ahb-lite registers
// Notes on behaviour
// - rectifiers low until soft start above 1 V
// - second pair only at 50% limit
// - fixed variant uses 50 ns dead time
// - primary fall to rectifier rise dead time
// - rectifier fall to primary rise dead time
// - unconfigured dead setting gives 8 ns minimum
// - dead spacing enforced only after soft start
// - blank current sense after primary turn-on
// - fixed variant blanks 50 ns, else programmed
// - minimum on-time is blanking plus logic delay
// - skip when error low and duty under 25%
// - skipping after soft start keeps rectifiers on
// - skipping during soft start keeps rectifiers off
// - equal skips on both primaries at 50%
// - decode limit: rail 100, open 75, ground 50
// - external sync 75% limit follows clock duty
// - set at cycle start, clear at current peak
// - switching frequency is half the sync clock
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "pwmseq_regs.svh"
module pwmseq_top (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        syncClock,          // internal or external sync clock, 2x switching
    input  wire logic        softStartAbove1v,   // comparator: soft start level over 1 V
    input  wire logic        errorAmpBelow03v,   // comparator: error amp level under 0.3 V
    input  wire logic        currentSenseTrip,   // comparator: sensed current reached reference
    input  wire logic        limitTiedRail,      // duty_limit_select strapped to regulator rail
    input  wire logic        limitTiedGround,    // duty_limit_select strapped to ground
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hsel,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             primaryDriveA,
    output logic             primaryDriveB,
    output logic             rectifierDriveA,
    output logic             rectifierDriveB
);
    // pin synchronisers: three stages, change accepted when stages two and three agree
    logic [2:0] syncSh_r [6];
    logic [2:0] syncSh_nxt [6];
    logic [5:0] pinIn;
    logic [5:0] pinClean_r;
    logic [5:0] pinClean_nxt;
    assign pinIn = {limitTiedGround, limitTiedRail, currentSenseTrip, errorAmpBelow03v, softStartAbove1v, syncClock};
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            syncSh_nxt[i] = {syncSh_r[i][1:0], pinIn[i]};
            pinClean_nxt[i] = (syncSh_r[i][1] == syncSh_r[i][2]) ? syncSh_r[i][2] : pinClean_r[i];
        end
    end
    // shift the pin samples along and keep the last agreed level
    always_ff @(posedge clock) begin
        for (int i = 0; i < 6; i++) begin
            syncSh_r[i] <= sys_rst ? 3'h0 : syncSh_nxt[i];
        end
        pinClean_r <= sys_rst ? 6'h00 : pinClean_nxt;
    end
    // cleaned pin levels by role
    logic syncLvl;
    logic ssDone;
    logic errLow;
    logic csTrip;
    assign syncLvl = pinClean_r[0];
    assign ssDone  = pinClean_r[1];
    assign errLow  = pinClean_r[2];
    assign csTrip  = pinClean_r[3];

    // ahb-lite slave registers
    logic [7:0]  ctrl_r, ctrl_nxt;       // control bits
    logic [7:0]  psDead_r, psDead_nxt;   // primary-to-rectifier dead count
    logic [7:0]  spDead_r, spDead_nxt;   // rectifier-to-primary dead count
    logic [7:0]  blank_r, blank_nxt;     // blanking count
    logic [7:0]  wrAddr_r, wrAddr_nxt;
    logic        wrPend_r, wrPend_nxt;
    logic [31:0] hrdata_nxt;
    logic [31:0] status;
    logic        acc;
    assign acc = hsel && hready && htrans[1];
    // writes land at the end of the data phase, reads answer in it
    always_comb begin
        ctrl_nxt   = ctrl_r;
        psDead_nxt = psDead_r;
        spDead_nxt = spDead_r;
        blank_nxt  = blank_r;
        wrPend_nxt = acc && hwrite;
        wrAddr_nxt = acc ? haddr[7:0] : wrAddr_r;
        hrdata_nxt = hrdata;
        if (wrPend_r) begin
            case (wrAddr_r)
                `PWMSEQ_ADDR_CTRL:    ctrl_nxt   = {4'h0, hwdata[3:0]};
                `PWMSEQ_ADDR_PS_DEAD: psDead_nxt = hwdata[7:0];
                `PWMSEQ_ADDR_SP_DEAD: spDead_nxt = hwdata[7:0];
                `PWMSEQ_ADDR_BLANK:   blank_nxt  = hwdata[7:0];
                default: ;
            endcase
        end
        if (acc && !hwrite) begin
            case (haddr[7:0])
                `PWMSEQ_ADDR_CTRL:    hrdata_nxt = {24'h000000, ctrl_r};
                `PWMSEQ_ADDR_PS_DEAD: hrdata_nxt = {24'h000000, psDead_r};
                `PWMSEQ_ADDR_SP_DEAD: hrdata_nxt = {24'h000000, spDead_r};
                `PWMSEQ_ADDR_BLANK:   hrdata_nxt = {24'h000000, blank_r};
                `PWMSEQ_ADDR_STATUS:  hrdata_nxt = status;
                default:              hrdata_nxt = 32'h00000000;
            endcase
        end
    end
    // register file and bus response flops
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_r    <= `PWMSEQ_CTRL_RST;
            psDead_r  <= `PWMSEQ_DEAD_RST;
            spDead_r  <= `PWMSEQ_DEAD_RST;
            blank_r   <= `PWMSEQ_BLANK_RST;
            wrPend_r  <= 1'b0;
            wrAddr_r  <= 8'h00;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            psDead_r  <= psDead_nxt;
            spDead_r  <= spDead_nxt;
            blank_r   <= blank_nxt;
            wrPend_r  <= wrPend_nxt;
            wrAddr_r  <= wrAddr_nxt;
            hrdata    <= hrdata_nxt;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // duty limit decode from the three-state strap
    pwmseq_pkg::pwmseq_limit_t limitSel;
    always_comb begin
        if (pinClean_r[4])      limitSel = pwmseq_pkg::PWMSEQ_LIM100;
        else if (pinClean_r[5]) limitSel = pwmseq_pkg::PWMSEQ_LIM50;
        else                    limitSel = pwmseq_pkg::PWMSEQ_LIM75;
    end
    logic dual;
    assign dual = (limitSel == pwmseq_pkg::PWMSEQ_LIM50);

    // effective timing counts
    logic       fixedVar;
    logic [7:0] psCyc;
    logic [7:0] spCyc;
    logic [7:0] blankCyc;
    logic [7:0] minOnCyc;
    assign fixedVar = ctrl_r[`PWMSEQ_CTRL_FIXED];
    always_comb begin
        if (fixedVar) begin
            psCyc    = 8'(`PWMSEQ_FIX_DEAD_CYC);
            spCyc    = 8'(`PWMSEQ_FIX_DEAD_CYC);
            blankCyc = 8'(`PWMSEQ_FIX_BLANK_CYC);
        end else begin
            psCyc    = ctrl_r[`PWMSEQ_CTRL_PS_SET] ? psDead_r : 8'(`PWMSEQ_MIN_DEAD_CYC);
            spCyc    = ctrl_r[`PWMSEQ_CTRL_SP_SET] ? spDead_r : 8'(`PWMSEQ_MIN_DEAD_CYC);
            blankCyc = (blank_r == 8'h00) ? 8'h01 : blank_r;
        end
        minOnCyc = 8'(blankCyc + 8'(`PWMSEQ_LOGIC_DLY_CYC));
    end

    // switching cycle: one per two sync clock edges of the same sense
    logic syncPrev_r;
    logic syncPrev_nxt;
    logic phase_r;      // high through the first half of a switching cycle
    logic phase_nxt;
    logic cycStart;
    logic edgeSel;      // sync edge at cycle start and cycle middle
    logic edgeOpp;      // opposite sync edge, at one and three quarters of a cycle
    // external sync is inverted internally, so start on the falling edge then
    assign edgeSel  = ctrl_r[`PWMSEQ_CTRL_EXTSYNC] ? (syncPrev_r && !syncLvl) : (!syncPrev_r && syncLvl);
    assign edgeOpp  = ctrl_r[`PWMSEQ_CTRL_EXTSYNC] ? (!syncPrev_r && syncLvl) : (syncPrev_r && !syncLvl);
    assign cycStart = edgeSel && !phase_r;
    // edge history and half-cycle phase
    always_comb begin
        syncPrev_nxt = syncLvl;
        phase_nxt    = edgeSel ? !phase_r : phase_r;
    end

    // per-cycle sequencing state
    typedef enum logic [2:0] {SQ_IDLE, SQ_SPDEAD, SQ_ON, SQ_PSDEAD, SQ_RECT} sq_state_t;
    sq_state_t   st_r, st_nxt;
    logic        side_r, side_nxt;     // 0 drives pair a, 1 drives pair b
    logic [15:0] cnt_r, cnt_nxt;       // cycles in current state
    logic [15:0] onLen_r, onLen_nxt;   // last on-time
    logic [15:0] period_r, period_nxt; // cycles since last cycle start
    logic [15:0] lastPer_r, lastPer_nxt;
    logic        skipA_r, skipA_nxt;   // pair a skipped; b must skip next
    logic        skipDue;
    logic        pA_nxt;
    logic        pB_nxt;
    logic        rA_nxt;
    logic        rB_nxt;
    logic        rectOn;
    logic        dutyLow;
    // previous on-time against previous period, both in clocks
    assign dutyLow = ({onLen_r, 2'b00} < {2'b00, lastPer_r});                  // under 25%
    assign skipDue = (dual && !side_r) ? skipA_r : (errLow && dutyLow);
    assign rectOn  = ssDone;
    assign status  = {24'h000000, limitSel, side_r, skipA_r, ssDone, 3'(st_r)};
    // next state of the sequencer and the drive levels that follow it
    always_comb begin
        st_nxt      = st_r;
        side_nxt    = side_r;
        cnt_nxt     = 16'(cnt_r + 16'h0001);
        onLen_nxt   = onLen_r;
        skipA_nxt   = skipA_r;
        period_nxt  = 16'(period_r + 16'h0001);
        lastPer_nxt = lastPer_r;
        if (cycStart) begin
            period_nxt  = 16'h0000;
            lastPer_nxt = period_r;
        end
        case (st_r)
            SQ_IDLE, SQ_RECT: begin
                if (cycStart) begin
                    cnt_nxt  = 16'h0000;
                    side_nxt = dual ? !side_r : 1'b0;
                    // a skipped a-side cycle makes the following b-side cycle skip too
                    if (!(dual ? !side_r : 1'b0)) skipA_nxt = errLow && dutyLow;
                    if (skipDue) begin
                        st_nxt    = (rectOn && st_r == SQ_RECT) ? SQ_RECT : SQ_IDLE;
                        onLen_nxt = 16'h0000;
                    end else begin
                        st_nxt = (rectOn && st_r == SQ_RECT) ? SQ_SPDEAD : SQ_ON;
                    end
                end else if (st_r == SQ_IDLE && rectOn) begin
                    st_nxt = SQ_RECT;
                end
            end
            SQ_SPDEAD: if (cnt_r >= {8'h00, spCyc}) begin
                st_nxt  = SQ_ON;
                cnt_nxt = 16'h0000;
            end
            SQ_ON: begin
                // ends on current trip after blanking, or at the duty limit
                if (cnt_r >= {8'h00, minOnCyc} && (csTrip ||
                    (limitSel == pwmseq_pkg::PWMSEQ_LIM50 && edgeSel && !cycStart) ||
                    (limitSel == pwmseq_pkg::PWMSEQ_LIM75 && edgeOpp && !phase_r) ||
                    cycStart)) begin
                    onLen_nxt = cnt_r;
                    cnt_nxt   = 16'h0000;
                    st_nxt    = rectOn ? SQ_PSDEAD : SQ_IDLE;
                end
            end
            SQ_PSDEAD: if (cnt_r >= {8'h00, psCyc}) begin
                st_nxt = rectOn ? SQ_RECT : SQ_IDLE;
            end
            default: st_nxt = SQ_IDLE;
        endcase
        // primaries and rectifiers from the next state; rectifier only outside on and dead states
        pA_nxt = (st_nxt == SQ_ON) && !side_nxt;
        pB_nxt = (st_nxt == SQ_ON) && side_nxt && dual;
        rA_nxt = (st_nxt == SQ_RECT) && rectOn && (!side_nxt || !dual);
        rB_nxt = (st_nxt == SQ_RECT) && rectOn && side_nxt && dual;
    end
    // sequencer state and registered drive outputs
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            syncPrev_r      <= 1'b0;
            phase_r         <= 1'b0;
            st_r            <= SQ_IDLE;
            side_r          <= 1'b1;
            cnt_r           <= 16'h0000;
            onLen_r         <= 16'h0000;
            period_r        <= 16'h0000;
            lastPer_r       <= 16'h0000;
            skipA_r         <= 1'b0;
            primaryDriveA   <= 1'b0;
            primaryDriveB   <= 1'b0;
            rectifierDriveA <= 1'b0;
            rectifierDriveB <= 1'b0;
        end else begin
            syncPrev_r      <= syncPrev_nxt;
            phase_r         <= phase_nxt;
            st_r            <= st_nxt;
            side_r          <= side_nxt;
            cnt_r           <= cnt_nxt;
            onLen_r         <= onLen_nxt;
            period_r        <= period_nxt;
            lastPer_r       <= lastPer_nxt;
            skipA_r         <= skipA_nxt;
            primaryDriveA   <= pA_nxt;
            primaryDriveB   <= pB_nxt;
            rectifierDriveA <= rA_nxt;
            rectifierDriveB <= rB_nxt;
        end
    end
endmodule

// ===== test/pwmseq_stage_model.sv
// behavioural power stage: sensed current ramps while a primary switch conducts
`timescale 1ns/1ps
module pwmseq_stage_model (
    input  wire logic       clock,
    input  wire logic       primaryDriveA,
    input  wire logic       primaryDriveB,
    input  wire logic [7:0] tripDelay,
    output logic            currentSenseTrip
);
    logic [7:0] rampCnt = 8'h00;
    // ramp grows while a switch is on, collapses once both are off
    always @(posedge clock) begin
        rampCnt <= (primaryDriveA || primaryDriveB) ? ((rampCnt == 8'hFF) ? rampCnt : rampCnt + 8'h01) : 8'h00;
    end
    assign currentSenseTrip = (primaryDriveA || primaryDriveB) && (rampCnt >= tripDelay);
endmodule

// ===== test/pwmseq_top_assertions.sv
// port assertions of the pwm output sequencer and their bind
`timescale 1ns/1ps
module pwmseq_top_assertions (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic softStartAbove1v,
    input wire logic limitTiedRail,
    input wire logic limitTiedGround,
    input wire logic primaryDriveA,
    input wire logic primaryDriveB,
    input wire logic rectifierDriveA,
    input wire logic rectifierDriveB
);
    logic ssSeen_r;
    logic ssSeen_nxt;
    // remembers that soft start has passed its threshold since reset
    always_comb ssSeen_nxt = ssSeen_r | softStartAbove1v;
    always_ff @(posedge clock) ssSeen_r <= sys_rst ? 1'b0 : ssSeen_nxt;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    chk_rect_softstart: assert property (!ssSeen_r |-> !rectifierDriveA && !rectifierDriveB)
        else $error("rectifier on during soft start");
    chk_b_pair_off: assert property ((limitTiedRail || !limitTiedGround) [*6] |-> !primaryDriveB && !rectifierDriveB)
        else $error("second pair on outside half limit");
    chk_overlap_a: assert property (!(primaryDriveA && rectifierDriveA))
        else $error("primary a and rectifier a both on");
    chk_overlap_b: assert property (!(primaryDriveB && rectifierDriveB))
        else $error("primary b and rectifier b both on");
    chk_ps_gap: assert property ($rose(rectifierDriveA) |-> !$past(primaryDriveA))
        else $error("rectifier rose without dead time");
    chk_sp_gap: assert property ($rose(primaryDriveA) && ssSeen_r |-> !$past(rectifierDriveA))
        else $error("primary rose without dead time");
    chk_min_on: assert property ($rose(primaryDriveA) |-> primaryDriveA [*3])
        else $error("primary pulse shorter than minimum");
    chk_ab_alternate: assert property (!(primaryDriveA && primaryDriveB))
        else $error("both primaries on together");
    // main scenarios reached
    cover property ($rose(rectifierDriveA));
    cover property ($rose(primaryDriveB));
    cover property ($fell(primaryDriveA) ##1 !primaryDriveA);
endmodule
bind pwmseq_top pwmseq_top_assertions i_chk (.clock, .sys_rst, .softStartAbove1v, .limitTiedRail, .limitTiedGround,
    .primaryDriveA, .primaryDriveB, .rectifierDriveA, .rectifierDriveB);

// ===== test/tb.sv
// self-checking bench of the pwm output sequencer
`timescale 1ns/1ps
`include "pwmseq_regs.svh"
module tb;
    logic        clock = 1'b0, sys_rst = 1'b1, syncClock = 1'b0, softStartAbove1v = 1'b0, errorAmpBelow03v = 1'b0;
    logic        limitTiedRail = 1'b1, limitTiedGround = 1'b0, hwrite = 1'b0, hsel = 1'b0, clr = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  tripDelay = 8'h14;
    logic        hreadyout, hresp, currentSenseTrip, pA, pB, rA;
    logic        primaryDriveA, primaryDriveB, rectifierDriveA, rectifierDriveB;
    int          fails = 0, samples_checked = 0, cyc = 0, nA, nB, nR, minOn, maxOn, minPs, minSp, onCnt, idle;
    logic [1:0]  straps [3] = '{2'b10, 2'b00, 2'b01};
    always #5 clock = ~clock;
    pwmseq_top i_dut (.clock, .sys_rst, .syncClock, .softStartAbove1v, .errorAmpBelow03v, .currentSenseTrip,
        .limitTiedRail, .limitTiedGround, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hsel,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .primaryDriveA, .primaryDriveB, .rectifierDriveA,
        .rectifierDriveB);
    pwmseq_stage_model i_stage (.clock, .primaryDriveA, .primaryDriveB, .tripDelay, .currentSenseTrip);
    // sync clock of 40 clocks a period, and the hang limit
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc % 20 == 19) syncClock <= ~syncClock;
        if (cyc == 20000) begin
            fails = fails + 1;
            wrap_up;
        end
    end
    // pulse counts, shortest and longest on time, and shortest gaps before each rising edge of primary a and rectifier a
    always @(posedge clock) begin
        pA <= primaryDriveA;
        pB <= primaryDriveB;
        rA <= rectifierDriveA;
        onCnt <= primaryDriveA ? onCnt + 1 : 0;
        idle <= (primaryDriveA || rectifierDriveA) ? 0 : idle + 1;
        if (clr) begin
            {nA, nB, nR} <= 0;
            minOn <= 255;
            minPs <= 255;
            minSp <= 255;
            maxOn <= 0;
        end else begin
            if (pA && !primaryDriveA && onCnt < minOn) minOn <= onCnt;
            if (pA && !primaryDriveA && onCnt > maxOn) maxOn <= onCnt;
            if (!rA && rectifierDriveA) begin
                nR <= nR + 1;
                if (idle < minPs) minPs <= idle;
            end
            if (!pA && primaryDriveA) begin
                nA <= nA + 1;
                if (idle < minSp) minSp <= idle;
            end
            if (!pB && primaryDriveB) nB <= nB + 1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        @(posedge clock);
        {haddr, htrans, hwrite, hsel} <= {addr, 2'b10, wr, 1'b1};
        do @(posedge clock); while (hreadyout !== 1'b1);
        {htrans, hsel, hwdata} <= {2'b00, 1'b0, data};
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic run(input int n);
        // let more than one switching period pass on the new settings, then measure
        repeat (100) @(posedge clock);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        repeat (n) @(posedge clock);
    endtask
    task automatic cfg(input logic [31:0] ctrl, ps, sp, blank, input logic [7:0] trip);
        ahb(1'b1, `PWMSEQ_ADDR_CTRL, ctrl);
        ahb(1'b1, `PWMSEQ_ADDR_PS_DEAD, ps);
        ahb(1'b1, `PWMSEQ_ADDR_SP_DEAD, sp);
        ahb(1'b1, `PWMSEQ_ADDR_BLANK, blank);
        tripDelay <= trip;
    endtask
    task automatic sc_regs;
        ahb(1'b0, `PWMSEQ_ADDR_CTRL, 0); chk(rd, 32'(`PWMSEQ_CTRL_RST));
        ahb(1'b0, `PWMSEQ_ADDR_SP_DEAD, 0); chk(rd, 32'(`PWMSEQ_DEAD_RST));
        ahb(1'b0, `PWMSEQ_ADDR_BLANK, 0); chk(rd, 32'(`PWMSEQ_BLANK_RST));
        ahb(1'b1, `PWMSEQ_ADDR_PS_DEAD, 32'h3); ahb(1'b0, `PWMSEQ_ADDR_PS_DEAD, 0); chk(rd, 32'h3);
        ahb(1'b1, 32'h20, 32'h7); ahb(1'b0, 32'h20, 0); chk(rd, 32'h0); chk(32'(hresp), 32'h0);
    endtask
    task automatic sc_softstart;
        run(800);
        chk(nR, 0);
        chk(32'(nA >= 9 && nA <= 11), 1);
        chk(nB, 0);
        errorAmpBelow03v <= 1'b1;
        tripDelay <= 8'h0;
        run(800);
        chk(nR, 0);
        chk(32'(nA <= 1), 1);
        errorAmpBelow03v <= 1'b0;
        tripDelay <= 8'h14;
    endtask
    task automatic sc_dead;
        cfg(32'h6, 32'h6, 32'h4, 32'h3, 8'h14);
        softStartAbove1v <= 1'b1;
        run(800);
        chk(32'(nR > 0), 1);
        chk(32'(minPs >= 6), 1);
        chk(32'(minSp >= 4), 1);
    endtask
    task automatic sc_unset_fixed;
        cfg(32'h0, 32'h6, 32'h6, 32'h1, 8'h0);
        run(800);
        chk(32'(minPs >= 1 && minPs < 6 && minSp < 6), 1);
        chk(32'(minOn >= 3), 1);
        cfg(32'h1, 32'h1, 32'h1, 32'h1, 8'h0);
        run(800);
        chk(32'(minPs >= 5 && minSp >= 5), 1);
        chk(32'(minOn >= 7), 1);
    endtask
    task automatic sc_half_skip;
        {limitTiedRail, limitTiedGround} <= 2'b01;
        cfg(32'h6, 32'h2, 32'h2, 32'h2, 8'h14);
        run(1600);
        chk(32'(nB >= 9 && nA - nB <= 1 && nB - nA <= 1), 1);
        errorAmpBelow03v <= 1'b1;
        tripDelay <= 8'h0;
        run(1600);
        chk(32'(nA < 9), 1);
        chk(32'(nA - nB <= 1 && nB - nA <= 1), 1);
        chk(32'(rectifierDriveA || rectifierDriveB), 1);
        errorAmpBelow03v <= 1'b0;
    endtask
    task automatic sc_limit75;
        {limitTiedRail, limitTiedGround} <= 2'b00;
        cfg(32'h6, 32'h2, 32'h2, 32'h2, 8'hFF);
        run(800);
        chk(32'(maxOn > 40 && maxOn <= 60), 1);
        cfg(32'hE, 32'h2, 32'h2, 32'h2, 8'hFF);
        run(800);
        chk(32'(maxOn > 40 && maxOn <= 60), 1);
        chk(32'(nA >= 9 && nA <= 11), 1);
    endtask
    task automatic sc_decode;
        for (int i = 0; i < 3; i++) begin
            {limitTiedRail, limitTiedGround} <= straps[i];
            repeat (8) @(posedge clock);
            ahb(1'b0, `PWMSEQ_ADDR_STATUS, 0);
            chk(32'(rd[7:6]), 32'(i));
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        sc_regs;
        sc_softstart;
        sc_dead;
        sc_unset_fixed;
        sc_half_skip;
        sc_limit75;
        sc_decode;
        wrap_up;
    end
endmodule
